/* hdl/set_state_event_timer.sv */
// state event timer: counters, match/capture, events, states, outputs
// How it works
// - one 32-bit or two 16-bit counters
// - clock from system clock or selected input
// - count up only, or up then down
// - eight registers, each match or capture
// - match events: irq, stop, limit, halt, reverse, toggle
// - counter copied into capture on event
// - six PWM outputs, common period
// - event: match, io condition, or both
// - events limit, halt, start, stop, reverse
// - events change state, toggle, interrupt, DMA
// - match zero acts as automatic limit
// - events qualified by count direction
// - match held pending until event fires
// - eight events, eight states, state masks
// - state kept across counter periods
// - four inputs each pick pin or internal
// - six outputs, one selected ADC trigger
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module set_state_event_timer (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clockEnable,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	input wire logic [set_pkg::NUM_IN-1:0] pinIn,
	input wire logic adcThresholdIrq,
	input wire logic comparatorOut,
	input wire logic coreEventOutput,
	input wire logic coreDebugHalt,
	output logic [set_pkg::NUM_OUT-1:0] timerOut,
	output logic adcTrigger,
	output logic irq,
	output logic [1:0] dmaReq
);
	import set_pkg::*;

	logic [31:0] cfgReg, ctrlReg, cntReg, ctrlNext;
	logic [31:0] matchReg [NUM_MATCH];
	logic [31:0] evCondReg [NUM_EV];
	logic [31:0] evActReg [NUM_EV];
	logic [11:0] inSelReg;
	logic [7:0] modeReg, statusReg, enableReg, pendReg;
	logic [15:0] dmaEnReg;
	logic [2:0] adcSelReg, stateReg, stateNext;
	logic dirLReg, dirHReg, unify, tick;
	logic [7:0] syncA, syncB, inVec, inOld, outVec, outOld;
	logic [3:0] inReg, inPrevReg;
	logic [5:0] outPrevReg, togMask;
	logic [7:0] fire, mRaw, evHi, capTrig;
	logic [1:0] run, limAct, haltAct, stopAct, startAct, revAct;
	logic [2:0] mIdx, ioIdx;
	logic mOk, ioNow, ioPrev, ioOk, evOk, dirNow, dirOk;
	logic limL, limH, stepL, stepH, clrL, clrH;
	logic [32:0] stL, stH;
	logic wrCfg, wrCtrl, wrCount, wrState, wrOut, wrMatch, wrEv;

	// compare against a match value in whole or split mode
	function automatic logic hitFn(input logic [31:0] c, input logic [31:0] m,
		input logic u, input logic h);
		if (u) begin
			hitFn = (c == m);
		end else if (h) begin
			hitFn = (c[31:16] == m[31:16]);
		end else begin
			hitFn = (c[15:0] == m[15:0]);
		end
	endfunction

	// one count step: returns {direction down, next value}
	function automatic logic [32:0] stepFn(input logic [31:0] v, input logic dn,
		input logic lim, input logic bid);
		if (!dn) begin
			if (lim) begin
				stepFn = bid ? {1'b1, v - 32'h1} : {1'b0, 32'h0};
			end else begin
				stepFn = {1'b0, v + 32'h1};
			end
		end else if (v == 32'h0) begin
			stepFn = {1'b0, v + 32'h1};
		end else begin
			stepFn = {1'b1, v - 32'h1};
		end
	endfunction

	assign wrCfg = regWr && regAddr == OFS_CFG;
	assign wrCtrl = regWr && regAddr == OFS_CTRL;
	assign wrCount = regWr && regAddr == OFS_COUNT;
	assign wrState = regWr && regAddr == OFS_STATE;
	assign wrOut = regWr && regAddr == OFS_OUT;
	assign wrMatch = regWr && regAddr[7:5] == OFS_MATCH[7:5];
	assign wrEv = regWr && regAddr[7:6] == OFS_EV[7:6];

	assign unify = cfgReg[CFG_UNIFY];
	assign run[0] = !ctrlReg[CTL_HALT] && !ctrlReg[CTL_STOP];
	assign run[1] = !ctrlReg[CTL_HI+CTL_HALT] && !ctrlReg[CTL_HI+CTL_STOP];
	assign inVec = {4'h0, inReg};
	assign inOld = {4'h0, inPrevReg};
	assign outVec = {2'h0, timerOut};
	assign outOld = {2'h0, outPrevReg};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			syncA <= 8'h00;
			syncB <= 8'h00;
		end else if (clockEnable) begin
			syncA <= {coreDebugHalt, coreEventOutput, comparatorOut,
				adcThresholdIrq, pinIn};
			syncB <= syncA;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			inReg <= 4'h0;
			inPrevReg <= 4'h0;
			outPrevReg <= 6'h00;
		end else if (clockEnable) begin
			for (int k = 0; k < NUM_IN; k++) begin
				inReg[k] <= syncB[inSelReg[3*k+:3]];
			end
			inPrevReg <= inReg;
			outPrevReg <= timerOut;
		end
	end

	// count tick from clock or input rising edge
	assign tick = !cfgReg[CFG_INCLK]
		|| (inReg[cfgReg[CFG_CLKSEL+:2]] && !inPrevReg[cfgReg[CFG_CLKSEL+:2]]);

	// event evaluation
	always_comb begin
		fire = 8'h00;
		mRaw = 8'h00;
		evHi = 8'h00;
		capTrig = 8'h00;
		togMask = 6'h00;
		limAct = 2'h0;
		haltAct = 2'h0;
		stopAct = 2'h0;
		startAct = 2'h0;
		revAct = 2'h0;
		mIdx = 3'h0;
		ioIdx = 3'h0;
		mOk = 1'b0;
		ioNow = 1'b0;
		ioPrev = 1'b0;
		ioOk = 1'b0;
		evOk = 1'b0;
		dirNow = 1'b0;
		dirOk = 1'b0;
		for (int e = 0; e < NUM_EV; e++) begin
			evHi[e] = evCondReg[e][EC_HSEL] & ~unify;
			mIdx = evCondReg[e][EC_MSEL+:3];
			mRaw[e] = ~modeReg[mIdx] & hitFn(cntReg, matchReg[mIdx], unify, evHi[e]);
			mOk = mRaw[e] | (evCondReg[e][EC_HOLD] & pendReg[e]);
			ioIdx = evCondReg[e][EC_IOSEL+:3];
			ioNow = evCondReg[e][EC_OSEL] ? outVec[ioIdx] : inVec[ioIdx];
			ioPrev = evCondReg[e][EC_OSEL] ? outOld[ioIdx] : inOld[ioIdx];
			unique case (evCondReg[e][EC_IOCND+:2])
				IO_LOW: ioOk = ~ioNow;
				IO_RISE: ioOk = ioNow & ~ioPrev;
				IO_FALL: ioOk = ~ioNow & ioPrev;
				IO_HIGH: ioOk = ioNow;
			endcase
			unique case (evCondReg[e][EC_COMB+:2])
				CB_OR: evOk = mOk | ioOk;
				CB_MATCH: evOk = mOk;
				CB_IO: evOk = ioOk;
				CB_AND: evOk = mOk & ioOk;
			endcase
			dirNow = evHi[e] ? dirHReg : dirLReg;
			case (evCondReg[e][EC_DIRQ+:2])
				DQ_UP: dirOk = ~dirNow;
				DQ_DOWN: dirOk = dirNow;
				default: dirOk = 1'b1;
			endcase
			fire[e] = evOk & dirOk & run[evHi[e]] & evActReg[e][EA_STMASK + stateReg];
			if (fire[e]) begin
				limAct[evHi[e]] = limAct[evHi[e]] | evActReg[e][EA_LIM];
				haltAct[evHi[e]] = haltAct[evHi[e]] | evActReg[e][EA_HALT];
				stopAct[evHi[e]] = stopAct[evHi[e]] | evActReg[e][EA_STOP];
				startAct[evHi[e]] = startAct[evHi[e]] | evActReg[e][EA_START];
				revAct[evHi[e]] = revAct[evHi[e]] | evActReg[e][EA_REV];
				togMask = togMask ^ evActReg[e][EA_TOG+:6];
				capTrig = capTrig | evActReg[e][EA_CAP+:8];
			end
		end
	end

	assign limL = limAct[0] || (cfgReg[CFG_AUTOL] && !modeReg[0]
		&& hitFn(cntReg, matchReg[0], unify, 1'b0));
	assign limH = limAct[1] || (cfgReg[CFG_AUTOH] && !modeReg[0]
		&& hitFn(cntReg, matchReg[0], 1'b0, 1'b1));
	assign stepL = tick && run[0];
	assign stepH = tick && run[1] && !unify;
	assign clrL = wrCtrl && regWrData[CTL_CLR];
	assign clrH = wrCtrl && regWrData[CTL_HI+CTL_CLR];
	assign stL = stepFn(unify ? cntReg : {16'h0000, cntReg[15:0]},
		dirLReg ^ revAct[0], limL, ctrlReg[CTL_BIDIR]);
	assign stH = stepFn({16'h0000, cntReg[31:16]},
		dirHReg ^ revAct[1], limH, ctrlReg[CTL_HI+CTL_BIDIR]);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cntReg <= 32'h0;
		end else if (clockEnable) begin
			if (wrCount) begin
				cntReg <= regWrData;
			end else if (unify) begin
				if (clrL) begin
					cntReg <= 32'h0;
				end else if (stepL) begin
					cntReg <= stL[31:0];
				end
			end else begin
				if (clrL) begin
					cntReg[15:0] <= 16'h0000;
				end else if (stepL) begin
					cntReg[15:0] <= stL[15:0];
				end
				if (clrH) begin
					cntReg[31:16] <= 16'h0000;
				end else if (stepH) begin
					cntReg[31:16] <= stH[15:0];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dirLReg <= 1'b0;
			dirHReg <= 1'b0;
		end else if (clockEnable) begin
			dirLReg <= clrL ? 1'b0 : (stepL ? stL[32] : dirLReg ^ revAct[0]);
			dirHReg <= clrH ? 1'b0 : (stepH ? stH[32] : dirHReg ^ revAct[1]);
		end
	end

	// halt, stop and start; hardware set wins over write
	always_comb begin
		ctrlNext = wrCtrl ? (regWrData & CTL_WMASK) : ctrlReg;
		for (int h = 0; h < 2; h++) begin
			if (haltAct[h]) begin
				ctrlNext[CTL_HI*h+CTL_HALT] = 1'b1;
			end
			if (startAct[h]) begin
				ctrlNext[CTL_HI*h+CTL_STOP] = 1'b0;
			end
			if (stopAct[h]) begin
				ctrlNext[CTL_HI*h+CTL_STOP] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrlReg <= CTRL_RST;
		end else if (clockEnable) begin
			ctrlReg <= ctrlNext;
		end
	end

	// lowest numbered firing event picks next state
	always_comb begin
		stateNext = stateReg;
		for (int e = NUM_EV - 1; e >= 0; e--) begin
			if (fire[e]) begin
				stateNext = evCondReg[e][EC_STLD] ? evCondReg[e][EC_STV+:3]
					: stateReg + evCondReg[e][EC_STV+:3];
			end
		end
	end

	// state untouched by counter wrap or limit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stateReg <= 3'h0;
		end else if (clockEnable) begin
			stateReg <= (|fire) ? stateNext : (wrState ? regWrData[2:0] : stateReg);
		end
	end

	// pending matches, consumed when the event fires
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pendReg <= 8'h00;
		end else if (clockEnable) begin
			for (int e = 0; e < NUM_EV; e++) begin
				pendReg[e] <= fire[e] ? 1'b0
					: pendReg[e] | (mRaw[e] & evCondReg[e][EC_HOLD]);
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int r = 0; r < NUM_MATCH; r++) begin
				matchReg[r] <= 32'h0;
			end
		end else if (clockEnable) begin
			for (int r = 0; r < NUM_MATCH; r++) begin
				if (capTrig[r] && modeReg[r]) begin
					matchReg[r] <= cntReg;
				end else if (wrMatch && regAddr[4:2] == r[2:0]) begin
					matchReg[r] <= regWrData;
				end
			end
		end
	end

	// configuration registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfgReg <= 32'h0;
			inSelReg <= 12'h000;
			modeReg <= 8'h00;
			enableReg <= 8'h00;
			dmaEnReg <= 16'h0000;
			adcSelReg <= 3'h0;
			for (int e = 0; e < NUM_EV; e++) begin
				evCondReg[e] <= 32'h0;
				evActReg[e] <= 32'h0;
			end
		end else if (clockEnable && regWr) begin
			unique case (regAddr)
				OFS_CFG: cfgReg <= regWrData & 32'h0000_003F;
				OFS_INSEL: inSelReg <= regWrData[11:0];
				OFS_MODE: modeReg <= regWrData[7:0];
				OFS_ENABLE: enableReg <= regWrData[7:0];
				OFS_DMAEN: dmaEnReg <= regWrData[15:0];
				OFS_ADCSEL: adcSelReg <= regWrData[2:0];
				default: begin
				end
			endcase
			if (wrEv && regAddr[2]) begin
				evActReg[regAddr[5:3]] <= regWrData;
			end else if (wrEv) begin
				evCondReg[regAddr[5:3]] <= regWrData;
			end
		end
	end

	// outputs toggled by events, PWM via limit and match
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			timerOut <= 6'h00;
			adcTrigger <= 1'b0;
		end else if (clockEnable) begin
			timerOut <= (wrOut ? regWrData[5:0] : timerOut) ^ togMask;
			// one output routed to the ADC trigger
			adcTrigger <= outVec[adcSelReg];
		end
	end

	// sticky status, set wins over clear; irq and DMA
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			statusReg <= 8'h00;
			irq <= 1'b0;
			dmaReq <= 2'h0;
		end else if (clockEnable) begin
			statusReg <= (statusReg & ~((regWr && regAddr == OFS_CLEAR)
				? regWrData[7:0] : 8'h00)) | fire;
			irq <= |(statusReg & enableReg);
			dmaReq[0] <= |(fire & dmaEnReg[7:0]);
			dmaReq[1] <= |(fire & dmaEnReg[15:8]);
		end
	end

	// register reads, data in the cycle after the strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 32'h0;
		end else if (clockEnable) begin
			regRdData <= 32'h0;
			if (regRd) begin
				unique case (regAddr)
					OFS_CFG: regRdData <= cfgReg;
					OFS_CTRL: regRdData <= ctrlReg;
					OFS_COUNT: regRdData <= cntReg;
					OFS_STATE: regRdData <= {29'h0, stateReg};
					OFS_INSEL: regRdData <= {20'h0, inSelReg};
					OFS_MODE: regRdData <= {24'h0, modeReg};
					OFS_OUT: regRdData <= {26'h0, timerOut};
					OFS_ADCSEL: regRdData <= {29'h0, adcSelReg};
					OFS_STATUS: regRdData <= {24'h0, statusReg};
					OFS_ENABLE: regRdData <= {24'h0, enableReg};
					OFS_DMAEN: regRdData <= {16'h0, dmaEnReg};
					default: begin
						if (regAddr[7:5] == OFS_MATCH[7:5]) begin
							regRdData <= matchReg[regAddr[4:2]];
						end else if (regAddr[7:6] == OFS_EV[7:6]) begin
							regRdData <= regAddr[2] ? evActReg[regAddr[5:3]]
								: evCondReg[regAddr[5:3]];
						end
					end
				endcase
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	haltHold_a: assert property (
		clockEnable && ctrlReg[CTL_HALT] && !regWr |=> $stable(cntReg[15:0]))
		else $error("halted counter moved");
	upCount_a: assert property (
		clockEnable && unify && stepL && !dirLReg && !revAct[0] && !limL && !regWr
		|=> cntReg == $past(cntReg) + 32'h1)
		else $error("up count did not advance by one");
	autoLimit_a: assert property (
		clockEnable && unify && stepL && limL && !dirLReg && !revAct[0]
		&& !ctrlReg[CTL_BIDIR] && !regWr |=> cntReg == 32'h0)
		else $error("limit did not return counter to zero");
	haltAct_a: assert property (
		clockEnable && haltAct[0] |=> ctrlReg[CTL_HALT])
		else $error("halt action ignored");
	stateKeep_a: assert property (
		clockEnable && fire == 8'h00 && !regWr |=> $stable(stateReg))
		else $error("state changed without event");
	capture_a: assert property (
		clockEnable && capTrig[2] && modeReg[2] |=> matchReg[2] == $past(cntReg))
		else $error("capture missed counter value");
	toggle_a: assert property (
		clockEnable && !regWr |=> timerOut == ($past(timerOut) ^ $past(togMask)))
		else $error("output toggle wrong");
	irqLevel_a: assert property (
		clockEnable && (statusReg & enableReg) != 8'h00 |=> irq)
		else $error("enabled status did not raise irq");
	stickySet_a: assert property (
		clockEnable && fire[0] |=> statusReg[0] [*2] or (statusReg[0] ##1 !statusReg[0]))
		else $error("event status lost");
	dmaPulse_a: assert property (
		clockEnable && (fire & dmaEnReg[7:0]) != 8'h00 |=> dmaReq[0])
		else $error("dma request missing");

	limitCycle_c: cover property (clockEnable && limL && stepL);
	stateMove_c: cover property (clockEnable && (|fire) && stateNext != stateReg);
	captureHit_c: cover property (clockEnable && capTrig != 8'h00);
	bidirTurn_c: cover property (dirLReg ##1 !dirLReg);
endmodule
`default_nettype wire

/* hdl/set_pkg.sv */
// constants for the state event timer: register map, fields, reset values
package set_pkg;
	localparam int NUM_MATCH = 8;
	localparam int NUM_EV = 8;
	localparam int NUM_OUT = 6;
	localparam int NUM_IN = 4;
	// byte addresses of the registers
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	localparam logic [7:0] OFS_INSEL = 8'h10;
	localparam logic [7:0] OFS_MODE = 8'h14;
	localparam logic [7:0] OFS_OUT = 8'h18;
	localparam logic [7:0] OFS_ADCSEL = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_CLEAR = 8'h24;
	localparam logic [7:0] OFS_ENABLE = 8'h28;
	localparam logic [7:0] OFS_DMAEN = 8'h2C;
	localparam logic [7:0] OFS_MATCH = 8'h40;
	localparam logic [7:0] OFS_EV = 8'h80;
	// configuration fields
	localparam int CFG_UNIFY = 0;
	localparam int CFG_INCLK = 1;
	localparam int CFG_CLKSEL = 2;
	localparam int CFG_AUTOL = 4;
	localparam int CFG_AUTOH = 5;
	// control fields, high half sits CTL_HI bits up
	localparam int CTL_HALT = 0;
	localparam int CTL_STOP = 1;
	localparam int CTL_BIDIR = 2;
	localparam int CTL_CLR = 3;
	localparam int CTL_HI = 16;
	localparam logic [31:0] CTL_WMASK = 32'h0007_0007;
	localparam logic [31:0] CTRL_RST = 32'h0001_0001;
	// event condition fields
	localparam int EC_MSEL = 0;
	localparam int EC_HSEL = 3;
	localparam int EC_OSEL = 4;
	localparam int EC_IOSEL = 5;
	localparam int EC_IOCND = 8;
	localparam int EC_COMB = 10;
	localparam int EC_DIRQ = 12;
	localparam int EC_HOLD = 14;
	localparam int EC_STLD = 15;
	localparam int EC_STV = 16;
	// event action fields
	localparam int EA_STMASK = 0;
	localparam int EA_LIM = 8;
	localparam int EA_HALT = 9;
	localparam int EA_STOP = 10;
	localparam int EA_START = 11;
	localparam int EA_REV = 12;
	localparam int EA_TOG = 13;
	localparam int EA_CAP = 19;
	// io condition and combination codes
	localparam logic [1:0] IO_LOW = 2'h0;
	localparam logic [1:0] IO_RISE = 2'h1;
	localparam logic [1:0] IO_FALL = 2'h2;
	localparam logic [1:0] IO_HIGH = 2'h3;
	localparam logic [1:0] CB_OR = 2'h0;
	localparam logic [1:0] CB_MATCH = 2'h1;
	localparam logic [1:0] CB_IO = 2'h2;
	localparam logic [1:0] CB_AND = 2'h3;
	localparam logic [1:0] DQ_UP = 2'h1;
	localparam logic [1:0] DQ_DOWN = 2'h2;
endpackage

/* tb/set_source_model.sv */
// input sources of the timer: four pins and four on-chip signals
`timescale 1ns/1ps
`default_nettype none
module set_source_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] srcSel,
	input wire logic [3:0] pulseNum,
	input wire logic pulseStart,
	output logic pulseBusy,
	output logic [3:0] pinIn,
	output logic adcThresholdIrq,
	output logic comparatorOut,
	output logic coreEventOutput,
	output logic coreDebugHalt
);
	logic [7:0] srcReg;
	logic [3:0] leftReg;
	logic [2:0] phaseReg;
	// selected source: low four cycles, high four cycles, per pulse
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			srcReg <= 8'h00;
			leftReg <= 4'h0;
			phaseReg <= 3'h0;
		end else if (pulseStart) begin
			leftReg <= pulseNum;
			phaseReg <= 3'h0;
		end else if (leftReg != 4'h0) begin
			phaseReg <= phaseReg + 3'h1;
			if (phaseReg == 3'h3) begin
				srcReg[srcSel] <= 1'b1;
			end
			if (phaseReg == 3'h7) begin
				srcReg[srcSel] <= 1'b0;
				leftReg <= leftReg - 4'h1;
			end
		end
	end
	assign pulseBusy = leftReg != 4'h0;
	assign pinIn = srcReg[3:0];
	assign adcThresholdIrq = srcReg[4];
	assign comparatorOut = srcReg[5];
	assign coreEventOutput = srcReg[6];
	assign coreDebugHalt = srcReg[7];
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking testbench of the state event timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import set_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic clockEnable = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [2:0] srcSel = 3'h0;
	logic [3:0] pulseNum = 4'h0;
	logic pulseStart = 1'b0;
	wire [31:0] regRdData;
	wire [3:0] pinIn;
	wire [5:0] timerOut;
	wire [1:0] dmaReq;
	wire adcThr, cmpOut, coreEv, coreHalt, adcTrigger, irq, pulseBusy;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int dmaPulses = 0;
	logic [31:0] v [12];

	set_state_event_timer DUT (.clock(clock), .nrst(nrst), .clockEnable(clockEnable),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .pinIn(pinIn), .adcThresholdIrq(adcThr),
		.comparatorOut(cmpOut), .coreEventOutput(coreEv), .coreDebugHalt(coreHalt),
		.timerOut(timerOut), .adcTrigger(adcTrigger), .irq(irq), .dmaReq(dmaReq));
	set_source_model sources (.clock(clock), .nrst(nrst), .srcSel(srcSel),
		.pulseNum(pulseNum), .pulseStart(pulseStart), .pulseBusy(pulseBusy),
		.pinIn(pinIn), .adcThresholdIrq(adcThr), .comparatorOut(cmpOut),
		.coreEventOutput(coreEv), .coreDebugHalt(coreHalt));

	always #25 clock = ~clock;
	always @(negedge clock) begin
		if (dmaReq[0] === 1'b1) begin
			dmaPulses++;
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] b(input int p);
		return 32'h1 << p;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	// n reads of one address back to back
	task automatic rdn(input logic [7:0] a, input int n);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			if (i == n - 1) begin
				regRd <= 1'b0;
			end
			#1 v[i] = regRdData;
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic doReset();
		@(posedge clock);
		nrst <= 1'b0;
		idle(10);
		nrst <= 1'b1;
	endtask
	task automatic pulses(input logic [2:0] s, input logic [3:0] n);
		@(posedge clock);
		srcSel <= s;
		pulseNum <= n;
		pulseStart <= 1'b1;
		@(posedge clock);
		pulseStart <= 1'b0;
		@(posedge clock);
		while (pulseBusy === 1'b1) @(posedge clock);
		idle(6);
	endtask

	initial begin
		logic [31:0] lim, e;
		logic up;
		void'($urandom(29268));
		idle(10);
		nrst <= 1'b1;
		rdn(OFS_CTRL, 1);
		check("ctrl", v[0], CTRL_RST);
		rdn(OFS_COUNT, 1);
		check("count", v[0], 32'h0);
		rdn(OFS_STATE, 1);
		check("state", v[0], 32'h0);
		check("outputs", {22'h0, timerOut, adcTrigger, irq, dmaReq}, 32'h0);
		for (int r = 0; r < 8; r++) begin
			e = $urandom;
			wr(8'(OFS_MATCH + 4 * r), e);
			rdn(8'(OFS_MATCH + 4 * r), 1);
			check("match", v[0], e);
		end
		rdn(8'h3C, 1);
		check("unmapped", v[0], 32'h0);
		$display("test reset and registers done");

		lim = 2 + $urandom % 8;
		wr(OFS_CFG, b(CFG_UNIFY) | b(CFG_AUTOL));
		wr(OFS_MATCH, lim);
		wr(OFS_CTRL, 32'h0);
		repeat (3) begin
			idle($urandom % 7);
			rdn(OFS_COUNT, 2);
			check("countRange", 32'(v[0] <= lim), 32'h1);
			check("countStep", v[1], (v[0] == lim) ? 32'h0 : v[0] + 1);
		end
		$display("test auto limit done");

		doReset();
		e = {16'($urandom), 16'hFFFE};
		wr(OFS_COUNT, e);
		rdn(OFS_COUNT, 1);
		check("countWrite", v[0], e);
		wr(OFS_CTRL, 32'h0001_0000);
		idle(2);
		rdn(OFS_COUNT, 2);
		check("countHigh", {16'h0, v[1][31:16]}, {16'h0, e[31:16]});
		check("countLow", {16'h0, v[1][15:0]}, {16'h0, v[0][15:0] + 16'h1});
		$display("test split counters done");

		doReset();
		wr(OFS_CFG, b(CFG_UNIFY) | b(CFG_AUTOL));
		wr(OFS_MATCH, 32'h4);
		wr(OFS_CTRL, b(CTL_BIDIR));
		rdn(OFS_COUNT, 12);
		up = v[1] > v[0];
		e = v[1];
		for (int i = 1; i < 11; i++) begin
			if (up && e == 4) begin
				up = 1'b0;
			end else if (!up && e == 0) begin
				up = 1'b1;
			end
			e = up ? e + 1 : e - 1;
			check("bidir", v[i + 1], e);
		end
		// down-only match at 2 halts: the count steps once more, to 1
		wr(8'(OFS_MATCH + 4), 32'h2);
		wr(OFS_EV, b(EC_MSEL) | (32'(CB_MATCH) << EC_COMB) | (32'(DQ_DOWN) << EC_DIRQ));
		wr(8'(OFS_EV + 4), 32'hFF | b(EA_HALT));
		idle(20);
		rdn(OFS_COUNT, 1);
		check("downOnly", v[0], 32'h1);
		rdn(OFS_CTRL, 1);
		check("haltEvent", {31'h0, v[0][CTL_HALT]}, 32'h1);
		$display("test up-down done");

		doReset();
		wr(OFS_CFG, b(CFG_UNIFY) | b(CFG_AUTOL));
		wr(OFS_MATCH, 32'h7);
		wr(8'(OFS_MATCH + 4), 32'h2);
		wr(OFS_MODE, b(2));
		wr(OFS_EV, b(EC_MSEL) | (32'(CB_MATCH) << EC_COMB) | b(EC_STLD) | (32'h3 << EC_STV));
		wr(8'(OFS_EV + 4), 32'h01 | b(EA_TOG + 3) | b(EA_CAP + 2));
		wr(8'(OFS_EV + 8), (32'(CB_IO) << EC_COMB) | (32'(IO_HIGH) << EC_IOCND));
		wr(8'(OFS_EV + 12), 32'h08 | b(EA_STOP));
		wr(OFS_ENABLE, 32'h1);
		wr(OFS_DMAEN, 32'h1);
		wr(OFS_ADCSEL, 32'h3);
		wr(OFS_CTRL, 32'h0);
		idle(40);
		check("irq", {31'h0, irq}, 32'h1);
		rdn(OFS_STATE, 1);
		check("stateKept", v[0], 32'h3);
		rdn(8'(OFS_MATCH + 8), 1);
		check("capture", v[0], 32'h2);
		check("toggle", {26'h0, timerOut}, 32'h8);
		check("adcTrig", {31'h0, adcTrigger}, 32'h1);
		check("dma", 32'(dmaPulses), 32'h1);
		pulses(3'h0, 4'h1);
		rdn(OFS_CTRL, 1);
		check("stopped", {31'h0, v[0][CTL_STOP]}, 32'h1);
		rdn(OFS_COUNT, 2);
		check("frozen", v[1], v[0]);
		rdn(OFS_STATUS, 1);
		check("status", v[0], 32'h3);
		wr(OFS_ENABLE, 32'h0);
		idle(3);
		check("irqMasked", {31'h0, irq}, 32'h0);
		wr(OFS_ENABLE, 32'h1);
		idle(3);
		check("irqUnmasked", {31'h0, irq}, 32'h1);
		wr(OFS_CLEAR, 32'h3);
		idle(3);
		check("irqCleared", {31'h0, irq}, 32'h0);
		rdn(OFS_STATUS, 1);
		check("statusClr", v[0], 32'h0);
		$display("test events done");

		// match at 3 held until the input goes high, fired once
		doReset();
		wr(OFS_CFG, b(CFG_UNIFY));
		wr(8'(OFS_MATCH + 4), 32'h3);
		wr(OFS_EV, b(EC_MSEL) | (32'(CB_AND) << EC_COMB) | (32'(IO_HIGH) << EC_IOCND)
			| b(EC_HOLD));
		wr(8'(OFS_EV + 4), 32'hFF | b(EA_TOG + 2));
		wr(OFS_CTRL, 32'h0);
		pulses(3'h0, 4'h1);
		check("heldMatch", {26'h0, timerOut}, 32'h4);
		$display("test held match done");

		doReset();
		wr(8'(OFS_EV + 16), (32'(CB_IO) << EC_COMB) | (32'(IO_RISE) << EC_IOCND));
		wr(8'(OFS_EV + 20), 32'hFF | b(EA_TOG + 1));
		wr(OFS_CFG, b(CFG_UNIFY) | b(CFG_INCLK));
		wr(OFS_CTRL, 32'h0);
		for (int s = 0; s < 8; s++) begin
			wr(OFS_INSEL, 32'(s));
			wr(OFS_COUNT, 32'h0);
			pulses(3'(s), 4'h3);
			rdn(OFS_COUNT, 1);
			check("inputClock", v[0], 32'h3);
			check("ioToggle", {31'h0, timerOut[1]}, 32'((s + 1) % 2));
		end
		$display("test input sources done");
		print_verdict();
	end
endmodule
`default_nettype wire
